//--- src/fpcd_fifo_port.sv
/*
 * FIFO port control: buffer clears, engine buffer swap, port ready settling
 * and the DMA request handshake for the CPU port (0) and the DMA port (1).
 * Assumes all inputs synchronous to core_clk_i and the engine reporting
 * packets, sends and activity per pipe.
 */
// Summary of operation
// - Clear strobe empties the CPU-side buffer of the selected pipe.
// - Engine-side clear with NAK and idle engine discards pending transmit data.
// - Auto clear mode clears a leftover DMA read buffer; zero does nothing.
// - Pipes 1 to 6 discard every received packet while their mode bit is zero.
// - Swap with NAK and idle engine hands engine-side data to the CPU port.
// - Swap raises packet ready event; never used on the default control pipe.
// - Engine-side clear raises packet ready and buffer empty events; not on DEFAULT_CONTROL_PIPE.
// - After pipe switch hold ready and length 20ns, low by 200ns, valid by 450ns.
// - With read count mode, length updates after each read within 150ns.
// - Without read count mode, length stays fixed during reads.
// - Double buffer completion: hold ready 20ns, other buffer valid by 300ns.
// - Only pipes 1 to 6 reach DMA, 16-bit or 8-bit wide.
// - Each DMA access is qualified by acknowledge or by address and select.
// - Cycle steal asserts the request once per transferred element.
// - Burst holds the request until the buffer is fully transferred.
// - Request asserts only while requests are enabled and the DMA pipe buffer is ready.
// - CPU bus with acknowledge uses read/write strobes and acknowledge.
// - CPU bus without acknowledge uses address hit and read/write strobes.
// - Split bus uses 8-bit data, acknowledge and the split strobe.
// - Burst bit zero selects cycle steal: request after each element.
module fpcd_fifo_port
    import fpcd_pkg::*;
#(
    parameter logic [6:0] DBL_MASK = DOUBLE_MASK
)
(
    input  wire logic              core_clk_i,
    input  wire logic              resetn_i,
    input  wire logic [PIPE_W-1:0] cpu_pipe_select_i,
    input  wire logic              control_pipe_direction_select_i,
    input  wire logic              cpu_read_count_mode_i,
    input  wire logic              cpu_rd_i,
    input  wire logic              cpu_wr_i,
    input  wire logic              cpu_side_buffer_clear_i,
    input  wire logic              buffer_valid_commit_i,
    input  wire logic              sie_side_buffer_clear_i,
    input  wire logic              cpu_sie_buffer_swap_i,
    input  wire logic              pipe_response_nak_i,
    input  wire fpcd_dma_cfg_t     dma_cfg_i,
    input  wire logic              dma_side_buffer_clear_i,
    input  wire logic              dma_buffer_valid_commit_i,
    input  wire logic              dma_rw_strobe_i,
    input  wire logic              split_bus_strobe_i,
    input  wire logic              dma_acknowledge_line_i,
    input  wire logic              dma_addr_cs_hit_i,
    input  wire logic [5:0]        pipe_transmit_dir_i,
    input  wire logic [5:0]        receive_auto_discard_mode_i,
    input  wire logic              se_deliver_i,
    input  wire logic              se_sent_i,
    input  wire logic              se_busy_i,
    input  wire logic [PIPE_W-1:0] se_pipe_i,
    input  wire logic [LEN_W-1:0]  se_len_i,
    input  wire logic [LEN_W-1:0]  se_side_len_i,
    output fpcd_port_stat_t        cpu_stat_o,
    output fpcd_port_stat_t        dma_stat_o,
    output logic                   sie_buffer_engaged_o,
    output logic                   packet_ready_event_o,
    output logic                   buffer_empty_event_o,
    output logic                   dma_request_line_o
);
    ////////////////////////////////////////////////////////////////////////////////
    if (DBL_MASK[0] || HOLD_CYC >= DBL_CYC || SWITCH_CYC >= (1 << TMR_W) || LEN_VALID_CYC < 2)
    begin : g_chk
        $error("fpcd_fifo_port: unsupported timing or double buffer mask");
    end

    logic [LEN_W-1:0]  cnt_r [NUM_PIPES];
    logic              rxf_r    [NUM_PIPES];
    logic              txv_r    [NUM_PIPES];
    logic [6:0]        dir_v;
    logic [6:0]        keep_v;
    logic [PIPE_W-1:0] p_sel    [2];
    logic [PIPE_W-1:0] p_idx    [2];
    logic [LEN_W-1:0]  p_cnt    [2];
    logic [LEN_W-1:0]  p_n      [2];
    logic [1:0]        p_ok;
    logic [1:0]        p_dir;
    logic [1:0]        p_acc;
    logic [1:0]        p_last;
    logic [1:0]        p_commit;
    logic [1:0]        p_clr;
    logic [1:0]        p_read_count_mode;
    logic [1:0]        p_live;
    logic [1:0]        p_switch;
    logic [1:0]        p_done;
    logic [1:0]        p_trig;
    fpcd_port_stat_t   p_stat_r [2];
    fpcd_port_state_t  p_state_r [2];
    logic              dma_strobe;
    logic              dma_qual;
    logic              dma_base;
    logic              dma_acc_d_r;
    logic              sie_side_buffer_clear_ok;
    logic              swap_ok;
    logic              auto_clr;
    logic              engaged_nxt;

    assign dir_v  = {pipe_transmit_dir_i, control_pipe_direction_select_i};
    assign keep_v = {receive_auto_discard_mode_i, 1'b1};

    ////////////////////////////////////////////////////////////////////////////////
    // DMA access qualification
    assign dma_strobe = dma_cfg_i.strobe_select ? split_bus_strobe_i
                                                : dma_rw_strobe_i;
    assign dma_qual   = dma_cfg_i.acknowledge_enable ? dma_acknowledge_line_i
                                                     : dma_addr_cs_hit_i;

    // Port 0 is the CPU port, port 1 the DMA port
    always_comb
    begin
        p_sel[0]  = cpu_pipe_select_i;
        p_sel[1]  = dma_cfg_i.port_pipe_select;
        p_ok[0]   = cpu_pipe_select_i <= DMA_LAST;
        p_ok[1]   = (p_sel[1] >= DMA_FIRST) && (p_sel[1] <= DMA_LAST);
        p_n[0]    = WIDE_BYTES;
        p_n[1]    = dma_cfg_i.data_bus_config ? SPLIT_BYTES : WIDE_BYTES;
        p_read_count_mode[0] = cpu_read_count_mode_i;
        p_read_count_mode[1] = dma_cfg_i.read_count_mode;
        p_commit  = {dma_buffer_valid_commit_i, buffer_valid_commit_i};
        p_clr     = {dma_side_buffer_clear_i, cpu_side_buffer_clear_i};
        for (int k = 0; k < 2; k++)
        begin
            p_idx[k]  = p_ok[k] ? p_sel[k] : DCP_PIPE;
            p_dir[k]  = dir_v[p_idx[k]];
            p_cnt[k]  = cnt_r[p_idx[k]];
            p_live[k] = p_ok[k] && (p_dir[k] ? !txv_r[p_idx[k]] : rxf_r[p_idx[k]]);
            p_last[k] = p_dir[k] ? (p_cnt[k] + p_n[k] >= PIPE_CAP[p_idx[k]])
                                 : (p_cnt[k] <= p_n[k]);
        end
        p_acc[0] = p_ok[0] && p_stat_r[0].ready && (p_dir[0] ? cpu_wr_i : cpu_rd_i);
        // Buffer state gates DMA so a stale ready never takes an extra element
        p_acc[1] = p_ok[1] && p_stat_r[1].ready && dma_strobe && dma_qual
                   && dma_cfg_i.dma_request_enable && p_live[1];
    end

    // Engine-side operations need NAK, an idle engine and a non-control pipe
    assign sie_side_buffer_clear_ok  = sie_side_buffer_clear_i && pipe_response_nak_i && !sie_buffer_engaged_o
                      && p_ok[0] && p_sel[0] != DCP_PIPE && p_dir[0];
    assign swap_ok  = cpu_sie_buffer_swap_i && pipe_response_nak_i && !sie_buffer_engaged_o
                      && p_ok[0] && p_sel[0] != DCP_PIPE && !p_dir[0];
    // A leftover smaller than one element can never be read out by DMA
    assign auto_clr = dma_cfg_i.auto_clear_after_read && p_ok[1] && !p_dir[1]
                      && rxf_r[p_idx[1]] && p_cnt[1] < p_n[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Per-pipe buffer state; hardware sets are applied last so they win
    for (genvar p = 0; p < NUM_PIPES; p++)
    begin : g_pipe
        always_ff @(posedge core_clk_i or negedge resetn_i)
        begin
            if (!resetn_i)
            begin
                cnt_r[p] <= '0;
                rxf_r[p] <= 1'b0;
                txv_r[p] <= 1'b0;
            end
            else
            begin
                for (int k = 0; k < 2; k++)
                begin
                    if (p_ok[k] && p_sel[k] == PIPE_W'(p))
                    begin
                        if (p_acc[k] && p_dir[k] && p_last[k])
                        begin
                            cnt_r[p] <= '0;
                            txv_r[p] <= 1'b1;
                        end
                        else if (p_acc[k] && p_dir[k])
                            cnt_r[p] <= cnt_r[p] + p_n[k];
                        else if (p_acc[k] && p_last[k])
                        begin
                            cnt_r[p] <= '0;
                            rxf_r[p] <= 1'b0;
                        end
                        else if (p_acc[k])
                            cnt_r[p] <= cnt_r[p] - p_n[k];
                        if (p_commit[k] && p_dir[k])
                        begin
                            cnt_r[p] <= '0;
                            txv_r[p] <= 1'b1;
                        end
                        if (p_clr[k] || (k == 1 && auto_clr))
                        begin
                            cnt_r[p] <= '0;
                            rxf_r[p] <= 1'b0;
                        end
                    end
                end
                if (sie_side_buffer_clear_ok && p_sel[0] == PIPE_W'(p))
                begin
                    cnt_r[p] <= '0;
                    txv_r[p] <= 1'b0;
                end
                if (swap_ok && p_sel[0] == PIPE_W'(p))
                begin
                    cnt_r[p] <= se_side_len_i;
                    rxf_r[p] <= 1'b1;
                end
                if (se_deliver_i && se_pipe_i == PIPE_W'(p) && !dir_v[p]
                    && !rxf_r[p] && keep_v[p])
                begin
                    cnt_r[p] <= se_len_i;
                    rxf_r[p] <= 1'b1;
                end
                if (se_sent_i && se_pipe_i == PIPE_W'(p) && dir_v[p])
                    txv_r[p] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port ready and length settling after a switch or a double buffer turn
    for (genvar k = 0; k < 2; k++)
    begin : g_port
        logic [PIPE_W:0] key_r;
        logic [PIPE_W:0] key_now;
        logic [TMR_W-1:0] tmr_r;
        logic [TMR_W-1:0] lim_r;

        assign key_now   = {p_sel[k], k == 0 && control_pipe_direction_select_i};
        assign p_switch[k] = key_now != key_r;
        assign p_done[k] = DBL_MASK[p_idx[k]] && p_ok[k]
                           && ((p_acc[k] && p_last[k]) || (p_commit[k] && p_dir[k]));
        assign p_trig[k] = p_switch[k] || p_done[k];

        always_ff @(posedge core_clk_i or negedge resetn_i)
        begin
            if (!resetn_i)
                key_r <= '0;
            else
                key_r <= key_now;
        end

        always_ff @(posedge core_clk_i or negedge resetn_i)
        begin
            if (!resetn_i)
            begin
                p_state_r[k] <= PS_LIVE;
                tmr_r        <= '0;
                lim_r        <= '0;
                p_stat_r[k]  <= '0;
            end
            else if (p_trig[k])
            begin
                // Old ready and length stay visible through the hold phase
                p_state_r[k] <= PS_HOLD;
                tmr_r        <= '0;
                lim_r        <= p_switch[k] ? TMR_W'(SWITCH_CYC) : TMR_W'(DBL_CYC);
            end
            else
            begin
                unique case (p_state_r[k])
                    PS_HOLD:
                    begin
                        tmr_r <= tmr_r + 1'b1;
                        if (tmr_r == TMR_W'(HOLD_CYC - 1))
                        begin
                            p_state_r[k]      <= PS_LOW;
                            p_stat_r[k].ready <= 1'b0;
                        end
                    end
                    PS_LOW:
                    begin
                        tmr_r <= tmr_r + 1'b1;
                        if (tmr_r == lim_r - 1'b1)
                        begin
                            p_state_r[k] <= PS_LIVE;
                            p_stat_r[k]  <= '{ready: p_live[k], length: p_cnt[k]};
                        end
                    end
                    PS_LIVE:
                    begin
                        p_stat_r[k].ready <= p_live[k];
                        // Frozen length while ready unless read count mode
                        if (p_read_count_mode[k] || !p_stat_r[k].ready)
                            p_stat_r[k].length <= p_cnt[k];
                    end
                endcase
            end
        end
    end

    assign cpu_stat_o = p_stat_r[0];
    assign dma_stat_o = p_stat_r[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Events and engine status
    assign engaged_nxt = se_busy_i && se_pipe_i == cpu_pipe_select_i;

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sie_buffer_engaged_o <= 1'b0;
            packet_ready_event_o <= 1'b0;
            buffer_empty_event_o <= 1'b0;
        end
        else
        begin
            sie_buffer_engaged_o <= engaged_nxt;
            packet_ready_event_o <= swap_ok || sie_side_buffer_clear_ok;
            buffer_empty_event_o <= sie_side_buffer_clear_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // DMA request
    // Ready lags the buffer by a cycle, so the live state ends the burst at once
    assign dma_base = dma_cfg_i.dma_request_enable && p_ok[1]
                      && dma_stat_o.ready && p_live[1];

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            dma_acc_d_r <= 1'b0;
        else
            dma_acc_d_r <= p_acc[1];
    end

    // Cycle steal drops the request for one cycle after every element
    assign dma_request_line_o = dma_base
                                && (dma_cfg_i.burst_mode || !dma_acc_d_r);

    ////////////////////////////////////////////////////////////////////////////////
    localparam int LOW_BOUND = LOW_MAX_CYC;
    localparam int SW_BOUND  = SWITCH_CYC + 1;
    localparam int DBL_BOUND = DBL_CYC + 1;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    req_disabled_a: assert property (
        !dma_cfg_i.dma_request_enable || !dma_stat_o.ready |-> !dma_request_line_o)
        else $error("DMA request while disabled or not ready");

    dma_pipes_a: assert property (
        dma_request_line_o |-> dma_cfg_i.port_pipe_select inside {[DMA_FIRST:DMA_LAST]})
        else $error("DMA request on a pipe outside 1 to 6");

    steal_gap_a: assert property (
        !dma_cfg_i.burst_mode && p_acc[1] |=> !dma_request_line_o)
        else $error("Cycle steal request not dropped after an element");

    burst_hold_a: assert property (
        dma_cfg_i.burst_mode && dma_base && $past(dma_request_line_o) |-> dma_request_line_o)
        else $error("Burst request dropped while buffer ready");

    switch_hold_a: assert property (
        p_switch[0] |=> $stable(cpu_stat_o) [*4])
        else $error("Port status changed inside hold time");

    switch_low_a: assert property (
        p_switch[1] && !(p_trig[1] && $past(p_trig[1])) |-> ##[1:LOW_BOUND] !dma_stat_o.ready)
        else $error("Ready not low in time after switch");

    switch_valid_a: assert property (
        p_switch[0] ##1 !p_trig[0] [*8] |-> ##[1:SW_BOUND]
        (p_state_r[0] == PS_LIVE || p_trig[0]))
        else $error("Port not valid in time after switch");

    dbl_valid_a: assert property (
        p_done[1] && !p_switch[1] ##1 !p_trig[1] [*8] |-> ##[1:DBL_BOUND]
        (p_state_r[1] == PS_LIVE || p_trig[1]))
        else $error("Other buffer not valid in time");

    len_frozen_a: assert property (
        !cpu_read_count_mode_i && p_acc[0] && p_state_r[0] == PS_LIVE |=>
        $stable(cpu_stat_o.length))
        else $error("Length moved during read without count mode");

    len_follow_a: assert property (
        cpu_read_count_mode_i && p_acc[0] && !p_trig[0] && p_state_r[0] == PS_LIVE
        ##1 (!p_trig[0] && cpu_read_count_mode_i) |=>
        cpu_stat_o.length == $past(p_cnt[0]))
        else $error("Length not updated after read");

    sie_side_buffer_clear_events_a: assert property (
        sie_side_buffer_clear_ok |=> packet_ready_event_o && buffer_empty_event_o)
        else $error("Engine-side clear events missing");

    swap_event_a: assert property (
        swap_ok |=> packet_ready_event_o && !buffer_empty_event_o)
        else $error("Swap event wrong");

    engaged_a: assert property (
        se_busy_i && se_pipe_i == cpu_pipe_select_i |=> sie_buffer_engaged_o)
        else $error("Engine engaged flag missing");

    burst_run_c: cover property (dma_cfg_i.burst_mode && p_acc[1] ##1 p_acc[1]);
    steal_run_c: cover property (!dma_cfg_i.burst_mode && p_acc[1] ##3 p_acc[1]);
    swap_c:      cover property (swap_ok);
    dbl_turn_c:  cover property (p_done[1] ##[1:DBL_BOUND] p_state_r[1] == PS_LIVE);
endmodule : fpcd_fifo_port

//--- src/fpcd_pkg.sv
/*
 * Shared constants, carriers and states for the FIFO port clear and DMA request block.
 * Assumes one 200 MHz core clock and an engine that reports packets per pipe.
 */
package fpcd_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    localparam int CLK_PERIOD_NS   = 5;
    localparam int HOLD_NS         = 20;
    localparam int LOW_MAX_NS      = 200;
    localparam int SWITCH_VALID_NS = 450;
    localparam int DBL_VALID_NS    = 300;
    localparam int LEN_VALID_NS    = 150;
    // Least times round up, longest times round down
    localparam int HOLD_CYC        = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOW_MAX_CYC     = LOW_MAX_NS / CLK_PERIOD_NS;
    localparam int SWITCH_CYC      = SWITCH_VALID_NS / CLK_PERIOD_NS;
    localparam int DBL_CYC         = DBL_VALID_NS / CLK_PERIOD_NS;
    localparam int LEN_VALID_CYC   = LEN_VALID_NS / CLK_PERIOD_NS;
    ////////////////////////////////////////////////////////////////////////////////
    localparam int                PIPE_W      = 3;
    localparam int                LEN_W       = 10;
    localparam int                TMR_W       = 7;
    localparam int                NUM_PIPES   = 7;
    localparam logic [PIPE_W-1:0] DCP_PIPE    = 3'h0;
    localparam logic [PIPE_W-1:0] DMA_FIRST   = 3'h1;
    localparam logic [PIPE_W-1:0] DMA_LAST    = 3'h6;
    localparam logic [6:0]        DOUBLE_MASK = 7'h06;
    localparam logic [LEN_W-1:0]  WIDE_BYTES  = 10'h002;
    localparam logic [LEN_W-1:0]  SPLIT_BYTES = 10'h001;
    localparam logic [LEN_W-1:0]  PIPE_CAP [NUM_PIPES] = '{
        10'h100, 10'h200, 10'h200, 10'h200, 10'h200, 10'h040, 10'h040};
    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic             ready;
        logic [LEN_W-1:0] length;
    } fpcd_port_stat_t;

    typedef struct packed {
        logic              data_bus_config;
        logic              dma_request_enable;
        logic              strobe_select;
        logic              acknowledge_enable;
        logic              burst_mode;
        logic              auto_clear_after_read;
        logic              read_count_mode;
        logic [PIPE_W-1:0] port_pipe_select;
    } fpcd_dma_cfg_t;

    typedef enum logic [1:0] {PS_LIVE, PS_HOLD, PS_LOW} fpcd_port_state_t;
endpackage : fpcd_pkg

//--- test/fpcd_dmac_model.sv
/*
 * Behavioural model of the external DMA controller on the DMA port.
 * Assumes the request line is sampled on core_clk_i; counts elements taken.
 */
module fpcd_dmac_model
    import fpcd_pkg::*;
(
    input  wire logic          core_clk_i,
    input  wire logic          resetn_i,
    input  wire fpcd_dma_cfg_t cfg_i,
    input  wire logic          dma_request_line_i,
    output logic               dma_rw_strobe_o,
    output logic               split_bus_strobe_o,
    output logic               dma_acknowledge_line_o,
    output logic               dma_addr_cs_hit_o,
    output logic [15:0]        taken_o
);
    logic act_r;
    // Steal mode backs off one cycle so a gap access is never sent
    always_ff @(posedge core_clk_i or negedge resetn_i)
        if (!resetn_i)
        begin
            act_r   <= 1'b0;
            taken_o <= 16'h0000;
        end
        else
        begin
            act_r <= dma_request_line_i && !(act_r && !cfg_i.burst_mode);
            if (act_r && dma_request_line_i)
                taken_o <= taken_o + 16'h0001;
        end
    assign dma_rw_strobe_o        = act_r && !cfg_i.strobe_select;
    assign split_bus_strobe_o     = act_r && cfg_i.strobe_select;
    assign dma_acknowledge_line_o = act_r && cfg_i.acknowledge_enable;
    assign dma_addr_cs_hit_o      = act_r && !cfg_i.acknowledge_enable;
endmodule : fpcd_dmac_model

//--- test/testbench.sv
/*
 * Self-checking bench for the FIFO port block with a DMA controller model.
 * Assumes the design ports as declared; DMA pipe 2 drains and settles between runs.
 */
module testbench;
    import fpcd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i, resetn_i, control_pipe_direction_select_i, cpu_read_count_mode_i;
    logic cpu_rd_i, cpu_wr_i, cpu_side_buffer_clear_i, buffer_valid_commit_i, se_busy_i;
    logic sie_side_buffer_clear_i, cpu_sie_buffer_swap_i, pipe_response_nak_i, se_sent_i;
    logic dma_side_buffer_clear_i, dma_buffer_valid_commit_i, dma_rw_strobe_i, se_deliver_i;
    logic split_bus_strobe_i, dma_acknowledge_line_i, dma_addr_cs_hit_i;
    logic sie_buffer_engaged_o, packet_ready_event_o, buffer_empty_event_o, dma_request_line_o;
    logic [PIPE_W-1:0] cpu_pipe_select_i, se_pipe_i;
    logic [LEN_W-1:0]  se_len_i, se_side_len_i, len;
    logic [5:0]        pipe_transmit_dir_i, receive_auto_discard_mode_i;
    logic [15:0]       taken, n0;
    fpcd_dma_cfg_t     dma_cfg_i;
    fpcd_port_stat_t   cpu_stat_o, dma_stat_o;
    int err_count, checks, cycles, seed;
    fpcd_fifo_port i_dut (.*);
    fpcd_dmac_model i_dmac (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .cfg_i(dma_cfg_i),
        .dma_request_line_i(dma_request_line_o), .dma_rw_strobe_o(dma_rw_strobe_i),
        .split_bus_strobe_o(split_bus_strobe_i), .dma_acknowledge_line_o(dma_acknowledge_line_i),
        .dma_addr_cs_hit_o(dma_addr_cs_hit_i), .taken_o(taken));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : cyc
    task automatic deliver(input logic [2:0] p, input logic [9:0] l);
        se_pipe_i = p;
        se_len_i = l;
        se_deliver_i = 1'b1;
        cyc(1);
        se_deliver_i = 1'b0;
    endtask : deliver
    task automatic test_done();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    // Generous ceiling: the sequence needs well under ten thousand cycles
    always @(posedge core_clk_i)
        if (++cycles >= 20000)
        begin
            err_count++;
            test_done();
        end
    initial
    begin
        seed = 32'h5a8d_f7f2;
        {resetn_i, control_pipe_direction_select_i, cpu_rd_i, cpu_wr_i, se_busy_i} = '0;
        {cpu_side_buffer_clear_i, buffer_valid_commit_i, sie_side_buffer_clear_i} = '0;
        {cpu_sie_buffer_swap_i, se_sent_i, dma_side_buffer_clear_i, se_deliver_i} = '0;
        {dma_buffer_valid_commit_i, se_side_len_i, se_len_i, se_pipe_i} = '0;
        {cpu_read_count_mode_i, pipe_response_nak_i, cpu_pipe_select_i} = {2'b11, 3'h3};
        {pipe_transmit_dir_i, receive_auto_discard_mode_i} = {6'h00, 6'h3f};
        dma_cfg_i = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 3'h2};
        cyc(16);
        resetn_i = 1'b1;
        cyc(95);
        len = 10'(({$random(seed)} % 100) * 2 + 6);
        deliver(3'h3, len);
        cyc(3);
        chk(16'(cpu_stat_o), {5'h00, 1'b1, len});
        cpu_pipe_select_i = 3'h4;
        cyc(3);
        chk(16'(cpu_stat_o), {5'h00, 1'b1, len});
        cyc(40);
        chk(16'(cpu_stat_o.ready), 16'h0000);
        cpu_pipe_select_i = 3'h3;
        cyc(92);
        chk(16'(cpu_stat_o.ready), 16'h0001);
        cpu_rd_i = 1'b1;
        cyc(1);
        cpu_rd_i = 1'b0;
        cyc(3);
        chk(16'(cpu_stat_o.length), 16'(len - 10'h002));
        cpu_read_count_mode_i = 1'b0;
        cpu_rd_i = 1'b1;
        cyc(1);
        cpu_rd_i = 1'b0;
        cyc(3);
        chk(16'(cpu_stat_o.length), 16'(len - 10'h002));
        cpu_side_buffer_clear_i = 1'b1;
        cyc(1);
        cpu_side_buffer_clear_i = 1'b0;
        cyc(3);
        chk(16'(cpu_stat_o.ready), 16'h0000);
        receive_auto_discard_mode_i = 6'h3b;
        deliver(3'h3, len);
        cyc(3);
        chk(16'(cpu_stat_o.ready), 16'h0000);
        $display("test cpu port done");
        se_busy_i = 1'b1;
        cyc(2);
        chk(16'(sie_buffer_engaged_o), 16'h0001);
        cpu_sie_buffer_swap_i = 1'b1;
        cyc(1);
        chk(16'(packet_ready_event_o), 16'h0000);
        se_busy_i = 1'b0;
        se_side_len_i = 10'({$random(seed)} % 256);
        cyc(2);
        cpu_sie_buffer_swap_i = 1'b0;
        chk(16'(packet_ready_event_o), 16'h0001);
        cyc(3);
        chk(16'(cpu_stat_o), {5'h00, 1'b1, se_side_len_i});
        pipe_transmit_dir_i = 6'h04;
        for (int k = 0; k < 2; k++)
        begin
            pipe_response_nak_i = k[0];
            sie_side_buffer_clear_i = 1'b1;
            cyc(1);
            sie_side_buffer_clear_i = 1'b0;
            chk(16'({packet_ready_event_o, buffer_empty_event_o}), 16'(k * 3));
            cyc(1);
        end
        $display("test engine side done");
        for (int m = 0; m < 6; m++)
        begin
            {dma_cfg_i.data_bus_config, dma_cfg_i.strobe_select} = {2{m % 3 == 2}};
            dma_cfg_i.acknowledge_enable = (m % 3 != 1);
            dma_cfg_i.burst_mode = (m >= 3);
            n0 = taken;
            len = 10'(({$random(seed)} % 32) * 2 + 2);
            deliver(3'h2, len);
            // Steal needs three cycles an element, and a double buffer turn adds 60
            cyc(3 * len + 80);
            chk(taken - n0, (m % 3 == 2) ? 16'(len) : 16'(len / 2));
            chk(16'(dma_request_line_o), 16'h0000);
        end
        dma_cfg_i.dma_request_enable = 1'b0;
        deliver(3'h2, 10'h004);
        cyc(3);
        chk(16'(dma_request_line_o), 16'h0000);
        dma_cfg_i.dma_request_enable = 1'b1;
        cyc(1);
        chk(16'(dma_request_line_o), 16'h0001);
        cyc(30);
        dma_cfg_i.port_pipe_select = DCP_PIPE;
        deliver(3'h2, 10'h004);
        cyc(3);
        chk(16'(dma_request_line_o), 16'h0000);
        dma_cfg_i.port_pipe_select = 3'h2;
        cyc(3);
        chk(16'(dma_request_line_o), 16'h0000);
        cyc(89);
        chk(16'(dma_request_line_o), 16'h0001);
        $display("test dma port done");
        test_done();
    end
endmodule : testbench
